// file: core/ftb_sram_ctrl.sv
// flow-through burst sram: access decode, burst stepping, byte writes, pin control
//
// Operation
// - interleaved order XORs start with 01,10,11
// - linear order counts up, wraps 11 to 00
// - sleep within three cycles, inputs ignored, tri-stated
// - load with any select inactive deselects
// - load, selects active, strobe high starts read
// - advance reads next address, ignores selects, strobe
// - read with gating off is dummy read
// - load, selects active, strobe low starts write
// - advance writes next address, lanes per beat
// - write start, no lanes selected, aborts
// - continue beat with no lanes writes nothing
// - clock qualify high freezes access state; gating and sleep still act
// - each selected lane writes data and parity
// - data pins tri-stated on any write
// - output gating unclocked by access, masked on writes
// - read data driven only while gating active
// - comes up deselected, pins tri-stated
// - no-lane write distinct from read
// - write data taken at following edge
// - access type held for whole burst
`timescale 1ns/10ps
`default_nettype none
module ftb_sram_ctrl
    import ftb_pkg::*;
#(
    parameter int LANES  = DEF_LANES,
    parameter int ADDR_W = DEF_ADDR_W
) (
    input  wire logic                         clk_sys,
    input  wire logic                         nrst,
    input  wire logic [ADDR_W-1:0]            addr,
    input  wire logic                         bank_select_first_n,
    input  wire logic                         bank_select_second,
    input  wire logic                         bank_select_third_n,
    input  wire logic                         advance_or_load_n,
    input  wire logic                         write_strobe_n,
    input  wire logic [LANES-1:0]             byte_lane_write_n,
    input  wire logic                         clock_qualify_n,
    input  wire logic                         output_gate_n,
    input  wire logic                         sleep_request,
    input  wire logic                         burst_order_interleave,
    input  wire logic [LANES*LANE_DATA_W-1:0] data_in,
    output var  logic [LANES*LANE_DATA_W-1:0] data_out,
    output var  logic                         data_oe,
    input  wire logic [LANES-1:0]             parity_in,
    output var  logic [LANES-1:0]             parity_out,
    output var  logic                         parity_oe,
    output var  logic                         sleeping
);

    localparam int DEPTH = 1 << ADDR_W;

    // geometry check: only the two documented word shapes are served
    // very wide addresses would ask for an array no simulator can hold
    if (!(LANES == 2 || LANES == 4)) begin : g_bad_lanes
        $error("ftb_sram_ctrl: LANES must be 2 or 4");
    end
    if (ADDR_W < BURST_BITS + 1 || ADDR_W > 24) begin : g_bad_addr
        $error("ftb_sram_ctrl: ADDR_W out of range");
    end

    // synchroniser stages for the three pins outside the clock
    logic               sleep_s1_q;    // first stage, read only by second
    logic               sleep_s2_q;    // sleep request, clock aligned
    logic               gate_s1_q;     // first stage of output gating
    logic               gate_s2_q;     // output gating, active low
    logic               order_s1_q;    // first stage of burst order strap
    logic               order_s2_q;    // burst order, high = interleaved

    // access state
    ftb_state_e         state_q;       // current access type
    ftb_state_e         state_d;
    logic [ADDR_W-1:0]  base_q;        // address latched at burst start
    logic [ADDR_W-1:0]  base_d;
    logic [1:0]         beat_q;        // beat number inside the burst
    logic [1:0]         beat_d;

    // pending write: address and lanes wait for data at the next edge
    logic               wr_pend_q;
    logic               wr_pend_d;
    logic [ADDR_W-1:0]  wr_addr_q;
    logic [LANES-1:0]   wr_skip_q;     // high = lane not written

    // read beat flag drives the pin enables
    logic               rd_beat_q;
    logic               rd_beat_d;

    // combinational decode
    logic               qualified;     // edge takes effect
    logic               selected;      // all three bank selects active
    logic               load;          // new address this edge
    logic [1:0]         next_bits;     // low bits of the next beat
    logic [ADDR_W-1:0]  acc_addr;      // address used by this edge
    logic               do_read;       // this edge is a read beat
    logic               do_write;      // this edge is a write beat
    logic               commit;        // pending write lands this edge
    logic               live;          // edge acts and the device is awake
    logic [1:0]         beat_next;     // beat number after the current one

    // per-lane read path
    logic [LANES*LANE_DATA_W-1:0] rd_data;
    logic [LANES-1:0]             rd_par;

    // output registers
    logic [LANES*LANE_DATA_W-1:0] data_out_q;
    logic [LANES-1:0]             parity_out_q;
    logic                         oe_q;
    logic                         sleeping_q;

    assign qualified = !clock_qualify_n;
    assign selected  = !bank_select_first_n && bank_select_second && !bank_select_third_n;
    assign load      = !advance_or_load_n;

    // the step wraps inside two bits; the cast keeps that cut deliberate
    assign beat_next = BURST_BITS'(beat_q + BEAT_STEP);

    // next burst address from the start address and the stepped beat
    ftb_burst_step u_step (
        .start_bits (base_q[BURST_BITS-1:0]),
        .beat       (beat_next),
        .interleave (order_s2_q),
        .addr_bits  (next_bits)
    );

    // two-stage synchronisers; gating runs every edge, even stalled ones
    // limitation: gating reaches the pins two or three edges late, the price of
    // registered enables on every output
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sleep_s1_q <= RST_SYNC;
            sleep_s2_q <= RST_SYNC;
            gate_s1_q  <= 1'b1;
            gate_s2_q  <= 1'b1;
            order_s1_q <= RST_ORDER;
            order_s2_q <= RST_ORDER;
        end else begin
            sleep_s1_q <= sleep_request;
            sleep_s2_q <= sleep_s1_q;
            gate_s1_q  <= output_gate_n;
            gate_s2_q  <= gate_s1_q;
            order_s1_q <= burst_order_interleave;
            order_s2_q <= order_s1_q;
        end
    end

    // access decode for one edge
    always_comb begin
        state_d   = state_q;
        base_d    = base_q;
        beat_d    = beat_q;
        acc_addr  = {base_q[ADDR_W-1:BURST_BITS], next_bits};
        if (sleep_s2_q) begin
            // sleep wins over everything, pending access is dropped
            state_d = FTB_SLEEP;
        end else if (!qualified) begin
            // stalled edge: nothing moves
            state_d = state_q;
        end else if (state_q == FTB_SLEEP) begin
            // leaving sleep always lands deselected
            state_d = FTB_DESEL;
        end else if (load) begin
            acc_addr = addr;
            base_d   = addr;
            beat_d   = BEAT_FIRST;
            if (!selected) begin
                state_d = FTB_DESEL;
            end else if (write_strobe_n) begin
                state_d = FTB_READ;
            end else begin
                state_d = FTB_WRITE;
            end
        end else if (state_q != FTB_DESEL) begin
            // continue: selects and strobe are not looked at
            beat_d = beat_next;
        end
    end

    // a sleeping device, or one just leaving sleep, takes no access on this edge
    assign live     = qualified && !sleep_s2_q && state_q != FTB_SLEEP;
    assign do_read  = live && state_d == FTB_READ;
    assign do_write = live && state_d == FTB_WRITE;
    assign commit   = qualified && !sleep_s2_q && wr_pend_q;

    // access state registers; reset lands deselected
    // base and beat survive sleep; the next load always rewrites them
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= FTB_DESEL;
            base_q  <= '0;
            beat_q  <= BEAT_FIRST;
        end else begin
            state_q <= state_d;
            base_q  <= base_d;
            beat_q  <= beat_d;
        end
    end

    // write pipeline: address and lane selects now, data one edge later
    // data follows its address by one edge, so address and lanes wait here
    always_comb begin
        wr_pend_d = wr_pend_q;
        if (sleep_s2_q) begin
            wr_pend_d = RST_PEND;
        end else if (qualified) begin
            wr_pend_d = do_write;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_pend_q <= RST_PEND;
            wr_addr_q <= '0;
            wr_skip_q <= '1;
        end else begin
            wr_pend_q <= wr_pend_d;
            if (do_write) begin
                // all lanes high makes a harmless abort beat
                wr_addr_q <= acc_addr;
                wr_skip_q <= byte_lane_write_n;
            end
        end
    end

    // one array per lane so each lane writes on its own
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LANE_W-1:0] mem [DEPTH];  // data and parity of this lane
        logic [LANE_W-1:0] wr_word;
        logic [LANE_W-1:0] rd_word;
        logic              lane_wr;

        // lane l carries its eight data bits plus parity bit l
        assign wr_word = {parity_in[l], data_in[l*LANE_DATA_W +: LANE_DATA_W]};
        assign lane_wr = commit && !wr_skip_q[l];

        // unselected lanes keep their old contents
        always_ff @(posedge clk_sys) begin
            if (lane_wr) begin
                mem[wr_addr_q] <= wr_word;
            end
        end

        // write landing at the same edge is forwarded to the read
        // without it a read straight after a write to that word returns old data
        always_comb begin
            if (lane_wr && wr_addr_q == acc_addr) begin
                rd_word = wr_word;
            end else begin
                rd_word = mem[acc_addr];
            end
        end

        assign rd_data[l*LANE_DATA_W +: LANE_DATA_W] = rd_word[LANE_DATA_W-1:0];
        assign rd_par[l] = rd_word[LANE_W-1];
    end

    // read data capture: flow-through, valid the cycle after the edge
    // held through stalls so the bus keeps seeing a steady word
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            data_out_q   <= '0;
            parity_out_q <= '0;
        end else if (do_read) begin
            // dummy reads fetch too; only the enable differs
            data_out_q   <= rd_data;
            parity_out_q <= rd_par;
        end
    end

    // read beat held through stalls, cleared by any other access
    // sleep clears it so the pins cannot reopen by themselves on waking
    always_comb begin
        rd_beat_d = rd_beat_q;
        if (sleep_s2_q || state_q == FTB_SLEEP) begin
            rd_beat_d = 1'b0;
        end else if (qualified) begin
            rd_beat_d = do_read;
        end
    end

    // pin enables follow gating every edge; writes mask gating
    // one shared enable keeps data and parity pins from ever disagreeing
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_beat_q  <= 1'b0;
            oe_q       <= RST_OE;
            sleeping_q <= 1'b0;
        end else begin
            rd_beat_q  <= rd_beat_d;
            // gating only ever opens the pins during a read beat
            oe_q       <= rd_beat_d && !gate_s2_q && !sleep_s2_q;
            sleeping_q <= sleep_s2_q;
        end
    end

    assign data_out   = data_out_q;
    assign parity_out = parity_out_q;
    assign data_oe    = oe_q;
    assign parity_oe  = oe_q;
    assign sleeping   = sleeping_q;

endmodule : ftb_sram_ctrl
`default_nettype wire

// file: common/ftb_pkg.sv
// shared constants and types of the flow-through burst sram control block
package ftb_pkg;

    // word layout: each byte lane holds eight data bits and one parity bit
    localparam int LANE_DATA_W       = 8;
    localparam int LANE_PAR_W        = 1;
    localparam int LANE_W            = LANE_DATA_W + LANE_PAR_W;

    // default geometry: four lanes, word of 36 bits, 256K words
    localparam int DEF_LANES         = 4;
    localparam int DEF_ADDR_W        = 18;

    // burst: low two address bits step through four beats
    localparam int BURST_BITS        = 2;
    localparam int BURST_LEN         = 4;

    // step values of the burst sequence
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_STEP  = 2'h1;

    // clock period and sleep timing
    localparam int CLK_PERIOD_PS     = 10000;
    localparam int SLEEP_ENTRY_CYC   = 2;
    localparam int SLEEP_RECOVER_CYC = 2;
    localparam int SLEEP_ENTRY_PS    = SLEEP_ENTRY_CYC * CLK_PERIOD_PS;
    localparam int SLEEP_RECOVER_PS  = SLEEP_RECOVER_CYC * CLK_PERIOD_PS;

    // reset values of control state
    localparam logic RST_PEND        = 1'b0;
    localparam logic RST_OE          = 1'b0;
    localparam logic RST_SYNC        = 1'b0;
    localparam logic RST_ORDER       = 1'b1;

    // access state, gray coded along desel -> read -> write -> sleep
    typedef enum logic [1:0] {
        FTB_DESEL = 2'h0,
        FTB_READ  = 2'h1,
        FTB_WRITE = 2'h3,
        FTB_SLEEP = 2'h2
    } ftb_state_e;

endpackage : ftb_pkg

// file: core/ftb_burst_step.sv
// burst address step: low two address bits for a given beat
`timescale 1ns/10ps
`default_nettype none
module ftb_burst_step
    import ftb_pkg::*;
(
    input  wire logic [BURST_BITS-1:0] start_bits,
    input  wire logic [BURST_BITS-1:0] beat,
    input  wire logic                  interleave,
    output var  logic [BURST_BITS-1:0] addr_bits
);

    // both orders wrap inside the four-word block by width alone
    always_comb begin
        if (interleave) begin
            addr_bits = start_bits ^ beat;
        end else begin
            addr_bits = BURST_BITS'(start_bits + beat);
        end
    end

endmodule : ftb_burst_step
`default_nettype wire

// file: sim/ftb_sram_ctrl_properties.sv
// pin-level assertions for the burst sram control block
`timescale 1ns/10ps
`default_nettype none
module ftb_sram_ctrl_properties
    import ftb_pkg::*;
#(
    parameter int LANES = DEF_LANES
) (
    input wire logic               clk_sys,
    input wire logic               nrst,
    input wire logic               bank_select_first_n,
    input wire logic               bank_select_second,
    input wire logic               bank_select_third_n,
    input wire logic               advance_or_load_n,
    input wire logic               write_strobe_n,
    input wire logic               clock_qualify_n,
    input wire logic               output_gate_n,
    input wire logic               sleep_request,
    input wire logic [LANES*8-1:0] data_out,
    input wire logic               data_oe,
    input wire logic [LANES-1:0]   parity_out,
    input wire logic               parity_oe,
    input wire logic               sleeping
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // edge the device acts on: not stalled, not asleep
    wire logic q_edge = !clock_qualify_n && !sleeping;
    // all three bank selects active
    wire logic sel_ok = !bank_select_first_n && bank_select_second && !bank_select_third_n;
    wire logic ld_ok  = q_edge && !advance_or_load_n && sel_ok;
    sequence s_write_start; ld_ok && !write_strobe_n; endsequence
    sequence s_advance; q_edge && advance_or_load_n; endsequence
    // gate low long enough to pass its synchroniser
    sequence s_gate_on; (!output_gate_n && !sleep_request && !sleeping)[*4]; endsequence

    a_read_drive: assert property (s_gate_on ##0 (ld_ok && write_strobe_n) |=> data_oe)
        else $error("data pins not driven after a gated read start");
    a_write_float: assert property (s_write_start |=> !data_oe)
        else $error("data pins driven after a write start");
    a_burst_write: assert property (s_write_start ##1 s_advance |=> !data_oe)
        else $error("data pins driven in a write burst beat");
    a_desel_float: assert property (q_edge && !advance_or_load_n && !sel_ok |=> !data_oe)
        else $error("data pins driven after a deselect");
    a_gate_off: assert property (output_gate_n [*4] |-> !data_oe)
        else $error("data pins driven with gating off");
    a_stall_hold: assert property (clock_qualify_n && !sleeping
        |=> $stable(data_out) && $stable(parity_out))
        else $error("read data moved on an ignored edge");
    a_sleep_entry: assert property (sleep_request [*4] |-> sleeping)
        else $error("sleep not entered in time");
    a_sleep_float: assert property (sleeping |-> !data_oe && !parity_oe)
        else $error("pins driven while asleep");
    a_pins_pair: assert property (parity_oe == data_oe)
        else $error("parity and data enables differ");
    a_reset_float: assert property ($rose(nrst) |-> !data_oe ##1 !data_oe)
        else $error("pins driven straight after reset");
endmodule : ftb_sram_ctrl_properties
bind ftb_sram_ctrl ftb_sram_ctrl_properties #(.LANES(LANES)) u_props (.clk_sys, .nrst,
    .bank_select_first_n, .bank_select_second, .bank_select_third_n, .advance_or_load_n,
    .write_strobe_n, .clock_qualify_n, .output_gate_n, .sleep_request, .data_out, .data_oe,
    .parity_out, .parity_oe, .sleeping);
`default_nettype wire

// file: sim/ftb_master_model.sv
// bus master model: drives the synchronous pins of the burst sram
`timescale 1ns/10ps
`default_nettype none
module ftb_master_model #(
    parameter int LN = 4,
    parameter int AW = 6
) (
    output var logic [AW-1:0]   addr,
    output var logic            bank_select_first_n,
    output var logic            bank_select_second,
    output var logic            bank_select_third_n,
    output var logic            advance_or_load_n,
    output var logic            write_strobe_n,
    output var logic [LN-1:0]   byte_lane_write_n,
    output var logic            clock_qualify_n,
    output var logic [LN*8-1:0] data_in,
    output var logic [LN-1:0]   parity_in
);
    // time zero: stalled, deselect load, no lanes
    initial begin
        {addr, bank_select_second, write_strobe_n, data_in, parity_in} = '0;
        {bank_select_first_n, bank_select_third_n, advance_or_load_n} = 3'h4;
        byte_lane_write_n = '1;
        clock_qualify_n = 1'b1;
    end
    // one edge of pins, changed just after a rising edge; sel 1..3 drops one select
    task automatic drive(input bit st_n, ld_n, input int sel, input bit w_n,
                         input logic [AW-1:0] a, input logic [LN-1:0] b,
                         input logic [LN*8-1:0] wd, input logic [LN-1:0] wp);
        clock_qualify_n     <= st_n;
        advance_or_load_n   <= ld_n;
        bank_select_first_n <= (sel == 1);
        bank_select_second  <= (sel != 2);
        bank_select_third_n <= (sel == 3);
        write_strobe_n      <= w_n;
        addr                <= a;
        byte_lane_write_n   <= b;
        data_in             <= wd;
        parity_in           <= wp; // parity bits exactly as passed in by the caller
    endtask : drive
endmodule : ftb_master_model
`default_nettype wire

// file: sim/ftb_sram_ctrl_test.sv
// self-checking bench of the burst sram control block
`timescale 1ns/10ps
`default_nettype none
module ftb_sram_ctrl_test
    import ftb_pkg::*;
;
    localparam int LN = 4;           // four lanes
    localparam int AW = 6;           // small array keeps the run short
    logic [AW-1:0]   addr;
    logic            bank_select_first_n, bank_select_second, bank_select_third_n;
    logic            advance_or_load_n, write_strobe_n, clock_qualify_n;
    logic [LN-1:0]   byte_lane_write_n, parity_in, parity_out;
    logic [LN*8-1:0] data_in, data_out;
    logic            data_oe, parity_oe, sleeping;
    logic            clk_sys = 1'b0, nrst = 1'b0;
    logic            output_gate_n = 1'b0, sleep_request = 1'b0, burst_order_interleave = 1'b1;
    logic [31:0]     m_d [64];       // model array, data lanes
    logic [3:0]      m_p [64];       // model array, parity bits
    logic [31:0]     exp_d;
    logic [3:0]      exp_p, pbw;
    logic            exp_oe = 1'b0;
    bit              chk_d = 1'b0, pend = 1'b0;
    int              st = 0, start = 0, beat = 0, pa = 0, settle = 4;
    int              n_fail = 0, checks_done = 0, seed = 73;

    ftb_master_model #(.LN(LN), .AW(AW)) m_master (.addr, .bank_select_first_n,
        .bank_select_second, .bank_select_third_n, .advance_or_load_n, .write_strobe_n,
        .byte_lane_write_n, .clock_qualify_n, .data_in, .parity_in);
    ftb_sram_ctrl #(.LANES(LN), .ADDR_W(AW)) u_ftb_sram_ctrl (.clk_sys, .nrst, .addr,
        .bank_select_first_n, .bank_select_second, .bank_select_third_n, .advance_or_load_n,
        .write_strobe_n, .byte_lane_write_n, .clock_qualify_n, .output_gate_n, .sleep_request,
        .burst_order_interleave, .data_in, .data_out, .data_oe, .parity_in, .parity_out,
        .parity_oe, .sleeping);

    always #5 clk_sys = ~clk_sys;

    task automatic chk(input string what, input logic [35:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    // one edge: drive it, check the edge before, then model it
    task automatic step(input bit st_n, ld_n, input int sel, input bit w_n,
                        input int a, input logic [3:0] b);
        logic [31:0] wd;
        logic [3:0]  wp;
        int          ad;
        wd = $random(seed);
        wp = 4'($random(seed));
        m_master.drive(st_n, ld_n, sel, w_n, a[AW-1:0], b, wd, wp);
        @(negedge clk_sys);
        if (settle == 0)
            chk("oe", {34'h0, parity_oe, data_oe}, {34'h0, exp_oe, exp_oe});
        if (chk_d && settle == 0)
            chk("rdata", {parity_out, data_out}, {exp_p, exp_d});
        if (settle > 0) settle--;
        if (!st_n) begin
            for (int l = 0; l < 4; l++)
                if (pend && !pbw[l]) begin
                    m_d[pa][8*l+:8] = wd[8*l+:8];
                    m_p[pa][l] = wp[l];
                end
            if (!ld_n) begin
                st = (sel inside {1, 2, 3}) ? 0 : (w_n ? 1 : 2);
                start = a & 63;
                beat = 0;
            end else if (st != 0) beat = (beat + 1) % 4;
            ad = (start & ~3) | ((burst_order_interleave ? start ^ beat : start + beat) & 3);
            exp_d = m_d[ad];
            exp_p = m_p[ad];
            pend = (st == 2);
            pa = ad;
            pbw = b;
        end
        // read beat holds through stalls, but the gate acts on every edge
        exp_oe = (st == 1) && !output_gate_n;
        chk_d = exp_oe;
        @(posedge clk_sys);
    endtask : step

    // about 700 cycles of traffic; far past that means a hang
    initial begin
        #50us;
        n_fail++;
        test_done();
    end

    initial begin
        logic [3:0] b;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        // fill every word with all lanes, selects and strobe junk on beats
        for (int a = 0; a < 64; a += 4) begin
            step(0, 0, 0, 0, a, 4'h0);
            repeat (3) step(0, 1, $random(seed), 1'($random(seed)), $random(seed), 4'h0);
        end
        // random mix: stalls, loads, deselects, aborts, gating windows, both orders
        for (int i = 0; i < 600; i++) begin
            if (i == 300) begin // strap settles behind deselects
                burst_order_interleave <= 1'b0;
                repeat (4) step(0, 0, 1, 1, 0, 4'h0);
            end
            if (i % 100 == 40 || i % 100 == 60) begin
                output_gate_n <= !output_gate_n;
                settle = 4;
            end
            b = ($random(seed) % 4 == 0) ? 4'hF : 4'($random(seed));
            step(($random(seed) % 5) == 0, ($random(seed) % 4) != 0, $random(seed) & 7,
                 1'($random(seed)), $random(seed), b);
        end
        step(0, 0, 1, 1, 0, 4'h0); // deselected before sleeping
        sleep_request <= 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("asleep", {34'h0, sleeping, data_oe}, 36'h2);
        @(posedge clk_sys);
        m_master.drive(0, 0, 0, 0, 6'h5, 4'h0, 32'h0, 4'h0); // write while asleep, ignored
        @(posedge clk_sys);
        m_master.drive(0, 0, 1, 1, 6'h0, 4'h0, 32'h0, 4'h0);
        sleep_request <= 1'b0;
        for (int i = 0; i < 8 && sleeping; i++) @(posedge clk_sys);
        settle = 4;
        repeat (3) step(0, 0, 1, 1, 0, 4'h0); // selects off through recovery
        step(0, 0, 0, 1, 5, 4'h0); // word 5 must be unaltered
        repeat (6) step(0, 0, 1, 1, 0, 4'h0);
        test_done();
    end
endmodule : ftb_sram_ctrl_test
`default_nettype wire
